// File: logic/iev_pkg.sv
// Constants, types and vector tables for the interrupt and exception vectoring block.
// Assumes a single system clock; all numbers here are shared by design and bench.
`default_nettype none
package iev_pkg;

	localparam int NUM_MASKABLE = 29;
	localparam int SRC_W        = 5;
	localparam int LEVEL_W      = 3;
	localparam int NUM_LEVELS   = 8;
	localparam int TRAP_W       = 5;
	localparam int NUM_TRAPS    = 32;

	// Default-priority index of the two DMA completion sources
	localparam int DMA0_SRC = 27;
	localparam int DMA1_SRC = 28;

	// Exception codes of the fixed sources
	localparam logic [15:0] CODE_RESET     = 16'h0000;
	localparam logic [15:0] CODE_NMI       = 16'h0010;
	localparam logic [15:0] CODE_TRAP_BASE = 16'h0040;
	localparam logic [15:0] CODE_EXC_TRAP  = 16'h0060;
	localparam logic [15:0] CODE_DMA0      = 16'h0290;
	localparam logic [15:0] CODE_DMA1      = 16'h02A0;

	// Maskable vector slots are 16 bytes apart, with unused slots left in place
	localparam logic [11:0] MASKABLE_BASE_SLOT = 12'h008;
	localparam logic [4:0]  GAP1_IDX           = 5'h05;
	localparam logic [11:0] GAP1_LEN           = 12'h002;
	localparam logic [4:0]  GAP2_IDX           = 5'h0F;
	localparam logic [11:0] GAP2_LEN           = 12'h004;

	// Least number of system clocks from request to handler start
	localparam logic [2:0] HANDLER_DELAY_CYC = 3'h4;

	// Reset values of the outputs
	localparam logic [15:0] RESET_CODE_VAL  = 16'h0000;
	localparam logic [31:0] RESET_ADDR_VAL  = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} iev_state_e;

	typedef logic [LEVEL_W-1:0] iev_level_t;

	typedef struct packed {
		logic [15:0] code;
		logic [31:0] addr;
	} iev_vector_s;

	typedef struct packed {
		logic              req;
		logic [TRAP_W-1:0] num;
	} iev_trap_s;

	typedef struct packed {
		logic       mask;
		iev_level_t level;
	} iev_irq_ctl_s;

	function automatic logic [15:0] maskable_code(input logic [SRC_W-1:0] idx);
		logic [11:0] slot;
		slot = {7'h00, idx} + MASKABLE_BASE_SLOT;
		if (idx >= GAP1_IDX) begin
			slot = slot + GAP1_LEN;
		end
		if (idx >= GAP2_IDX) begin
			slot = slot + GAP2_LEN;
		end
		return {slot, 4'h0};
	endfunction

	// Handler address: code zero-extended, trap sub-number dropped
	function automatic logic [31:0] handler_addr(input logic [15:0] code);
		return {16'h0000, code[15:4], 4'h0};
	endfunction

endpackage
`default_nettype wire

// File: logic/iev_vectoring.sv
// Functional notes
// - 32 traps, codes 004n and 005n
// - Illegal opcode and debug trap share 0060
// - DMA channel 0 done: priority 27, 0290
// - DMA channel 1 done: priority 28, 02A0
// - Simultaneous maskables: lowest programmed level wins, then lowest default priority
// - Nonmaskable request beats all but reset, ignores disable
// - Eight programmable levels drive nested acceptance
// - At least four clocks before handler start
//
// Vector and priority selection between interrupt sources and the core.
// Assumes requests are one-cycle pulses synchronous to clk_in and that the
// core reports its interrupt enable, in-service state and current level.
`timescale 1ns/1ps
`default_nettype none
module iev_vectoring (
	input  wire logic                                        clk_in,
	input  wire logic                                        rst_b_in,
	input  wire logic                                        ce_in,
	input  wire logic                                        nonmaskable_request_in,
	input  wire iev_pkg::iev_trap_s                          trap_in,
	input  wire logic                                        illegal_opcode_trap_in,
	input  wire logic                                        debug_trap_in,
	input  wire logic [iev_pkg::NUM_MASKABLE-3:0]            periph_req_in,
	input  wire iev_pkg::iev_irq_ctl_s [iev_pkg::NUM_MASKABLE-3:0] periph_ctl_in,
	input  wire logic                                        dma_ch0_done_irq_in,
	input  wire logic                                        dma_ch1_done_irq_in,
	input  wire iev_pkg::iev_irq_ctl_s                       dma_ch0_irq_ctl_in,
	input  wire iev_pkg::iev_irq_ctl_s                       dma_ch1_irq_ctl_in,
	input  wire logic                                        int_enable_in,
	input  wire logic                                        in_service_in,
	input  wire iev_pkg::iev_level_t                         cur_level_in,
	output iev_pkg::iev_vector_s                             vector_out,
	output logic                                             start_out,
	output logic                                             start_maskable_out,
	output iev_pkg::iev_level_t                              start_level_out,
	output logic                                             busy_out
);

	localparam int N = iev_pkg::NUM_MASKABLE;

	iev_pkg::iev_state_e             state_r;
	iev_pkg::iev_state_e             state_nxt;
	logic [2:0]                      cnt_r;
	logic                            reset_pend_r;
	logic                            nmi_pend_r;
	logic                            exc_pend_r;
	logic [15:0]                     exc_code_r;
	logic [N-1:0]                    pend_r;
	logic [N-1:0]                    pend_nxt;
	iev_pkg::iev_vector_s            vec_r;
	logic                            start_r;
	logic                            maskable_r;
	iev_pkg::iev_level_t             level_r;
	logic                            busy_r;

	wire logic [N-1:0]               req_all;
	iev_pkg::iev_irq_ctl_s [N-1:0]   ctl_all;
	logic [N-1:0]                    elig;
	logic                            win_valid;
	logic [iev_pkg::SRC_W-1:0]       win_idx;
	iev_pkg::iev_level_t             win_lvl;
	wire logic                       take;
	wire logic                       take_maskable;
	wire logic                       exc_in;
	wire logic [15:0]                exc_code_in;
	wire logic [15:0]                sel_code;
	wire logic                       wait_done;

	assign req_all = {dma_ch1_done_irq_in, dma_ch0_done_irq_in, periph_req_in};
	assign ctl_all = {dma_ch1_irq_ctl_in, dma_ch0_irq_ctl_in, periph_ctl_in};

	// Pending latch and eligibility per maskable source
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			// New request wins over the clear of its own acceptance
			assign pend_nxt[g] = req_all[g]
				| (pend_r[g] & ~(take_maskable && (int'(win_idx) == g)));
			assign elig[g] = pend_r[g] & ~ctl_all[g].mask & int_enable_in
				& (~in_service_in | (ctl_all[g].level < cur_level_in));
		end
	endgenerate

	// Lowest programmed level first, then lowest default priority
	always_comb begin
		win_valid = 1'b0;
		win_idx   = '0;
		win_lvl   = '1;
		for (int i = N - 1; i >= 0; i--) begin
			if (elig[i] && (!win_valid || ctl_all[i].level <= win_lvl)) begin
				win_valid = 1'b1;
				win_idx   = i[iev_pkg::SRC_W-1:0];
				win_lvl   = ctl_all[i].level;
			end
		end
	end

	assign exc_in      = illegal_opcode_trap_in | debug_trap_in | trap_in.req;
	assign exc_code_in = (illegal_opcode_trap_in | debug_trap_in) ? iev_pkg::CODE_EXC_TRAP
		: (iev_pkg::CODE_TRAP_BASE | {11'h000, trap_in.num});

	// Fixed order: reset, nonmaskable, exceptions, maskable
	assign sel_code = reset_pend_r ? iev_pkg::CODE_RESET
		: nmi_pend_r ? iev_pkg::CODE_NMI
		: exc_pend_r ? exc_code_r
		: iev_pkg::maskable_code(win_idx);

	assign take          = (state_r == iev_pkg::ST_IDLE) && !start_r
		&& (reset_pend_r | nmi_pend_r | exc_pend_r | win_valid);
	assign take_maskable = take && !reset_pend_r && !nmi_pend_r && !exc_pend_r;
	assign wait_done     = (cnt_r == iev_pkg::HANDLER_DELAY_CYC - 3'h1);

	// Take only happens in idle, so the wait state never sees it
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			iev_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = iev_pkg::ST_WAIT;
				end
			end
			iev_pkg::ST_WAIT: begin
				if (wait_done) begin
					state_nxt = iev_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = iev_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= iev_pkg::ST_IDLE;
			cnt_r   <= 3'h0;
			start_r <= 1'b0;
			busy_r  <= 1'b0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			cnt_r   <= take ? 3'h1 : (state_r == iev_pkg::ST_WAIT) ? cnt_r + 3'h1 : 3'h0;
			start_r <= (state_r == iev_pkg::ST_WAIT) && wait_done;
			busy_r  <= (state_nxt == iev_pkg::ST_WAIT);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reset_pend_r <= 1'b1;
			nmi_pend_r   <= 1'b0;
			exc_pend_r   <= 1'b0;
			exc_code_r   <= iev_pkg::RESET_CODE_VAL;
			pend_r       <= '0;
		end else if (ce_in) begin
			reset_pend_r <= reset_pend_r & ~take;
			nmi_pend_r   <= nonmaskable_request_in | (nmi_pend_r & ~(take && !reset_pend_r));
			exc_pend_r   <= exc_in | (exc_pend_r & ~(take && !reset_pend_r && !nmi_pend_r));
			exc_code_r   <= exc_in ? exc_code_in : exc_code_r;
			pend_r       <= pend_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			vec_r      <= '{code: iev_pkg::RESET_CODE_VAL, addr: iev_pkg::RESET_ADDR_VAL};
			maskable_r <= 1'b0;
			level_r    <= '0;
		end else if (ce_in && take) begin
			vec_r      <= '{code: sel_code, addr: iev_pkg::handler_addr(sel_code)};
			maskable_r <= take_maskable;
			level_r    <= take_maskable ? win_lvl : level_r;
		end
	end

	assign vector_out         = vec_r;
	assign start_out          = start_r;
	assign start_maskable_out = maskable_r;
	assign start_level_out    = level_r;
	assign busy_out           = busy_r;

	// Helper: some eligible source beats the chosen one
	logic better_exists;
	always_comb begin
		better_exists = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (elig[i] && ((ctl_all[i].level < win_lvl)
				|| ((ctl_all[i].level == win_lvl) && (i < int'(win_idx))))) begin
				better_exists = 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	a_trap_code_map: assert property ((ce_in && trap_in.req && !illegal_opcode_trap_in
		&& !debug_trap_in) |=> exc_pend_r && exc_code_r == {11'h002, $past(trap_in.num)})
		else $error("trap code not 004n or 005n");
	a_exc_trap_code: assert property ((ce_in && (illegal_opcode_trap_in || debug_trap_in))
		|=> exc_code_r == 16'h0060)
		else $error("exception trap code not 0060");
	a_dma0_vector: assert property ((take_maskable && ce_in && win_idx == 5'h1B)
		|=> vec_r.code == 16'h0290 && vec_r.addr == 32'h0000_0290)
		else $error("dma channel 0 vector wrong");
	a_dma1_vector: assert property ((take_maskable && ce_in && win_idx == 5'h1C)
		|=> vec_r.code == 16'h02A0 && vec_r.addr == 32'h0000_02A0)
		else $error("dma channel 1 vector wrong");
	a_default_prio: assert property (win_valid |-> elig[win_idx] && !better_exists)
		else $error("maskable winner not the most urgent");
	a_nmi_first: assert property ((take && ce_in && nmi_pend_r && !reset_pend_r)
		|=> vec_r.code == 16'h0010 && !maskable_r)
		else $error("nonmaskable request not taken first");
	a_nest_level: assert property ((win_valid && in_service_in) |-> win_lvl < cur_level_in)
		else $error("nested request not above current level");
	a_wait_min: assert property ((take && ce_in) |=> !start_r [*3])
		else $error("handler start too early");
	a_wait_done: assert property ((take && ce_in) ##1 ce_in [*3] |=> start_r && !busy_out)
		else $error("handler start missing after wait");
	a_addr_align: assert property (start_r |-> vec_r.addr[3:0] == 4'h0
		&& vec_r.addr[31:16] == 16'h0000 && vec_r.addr[15:4] == vec_r.code[15:4])
		else $error("handler address not code aligned");
	a_busy_wait: assert property ((take && ce_in) |=> busy_out && !start_out)
		else $error("busy not raised after take");
	a_mask_gate: assert property (win_valid |-> !ctl_all[win_idx].mask && int_enable_in)
		else $error("masked or disabled request eligible");
	a_reset_vector: assert property ((take && ce_in && reset_pend_r)
		|=> vec_r.code == 16'h0000 && vec_r.addr == 32'h0000_0000)
		else $error("reset vector not at address zero");

	c_reset_vector: cover property (start_r && vec_r.code == 16'h0000);
	c_dma0_taken:   cover property (start_r && maskable_r && vec_r.code == 16'h0290);
	c_nmi_over_irq: cover property (take && nmi_pend_r && win_valid && !reset_pend_r);
	c_nested:       cover property (take_maskable && in_service_in);
	c_exc_trap:     cover property (take && exc_pend_r && !nmi_pend_r && !reset_pend_r);

endmodule // iev_vectoring
`default_nettype wire

// File: testbench/iev_core_model.sv
// Core-side model: enters service on a maskable start, leaves after HOLD clocks.
// Assumes the vectoring block's start outputs are registers on clk_in.
`timescale 1ns/1ps
`default_nettype none
module iev_core_model #(
	parameter int HOLD = 30
) (
	input  wire logic                clk_in,
	input  wire logic                rst_b_in,
	input  wire logic                on_in,
	input  wire logic                start_in,
	input  wire logic                maskable_in,
	input  wire iev_pkg::iev_level_t level_in,
	output logic                     in_service_out,
	output iev_pkg::iev_level_t      cur_level_out
);
	int cnt_r;
	// A nested start replaces the level and restarts the service time
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_r <= 0;
			cur_level_out <= '0;
		end else if (start_in && maskable_in && on_in) begin
			cnt_r <= HOLD;
			cur_level_out <= level_in;
		end else if (cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
		end
	end
	assign in_service_out = (cnt_r > 0);
endmodule // iev_core_model
`default_nettype wire

// File: testbench/tb_iev_vectoring.sv
// Self-checking bench for the vectoring block: table of sources, then priority cases.
// Assumes iev_pkg and iev_vectoring are compiled first; clock enable driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_iev_vectoring;
	typedef struct packed {
		logic [2:0]  kind;
		logic [4:0]  arg;
		logic [15:0] code;
		logic        mk;
	} iev_row_s;
	logic                         clk_in, rst_b_in, nmi, ill, dbg, dma0, dma1, ien, core_on, ce;
	iev_pkg::iev_trap_s           trap;
	logic [26:0]                  preq;
	iev_pkg::iev_irq_ctl_s [26:0] pctl;
	iev_pkg::iev_irq_ctl_s        d0ctl, d1ctl;
	iev_pkg::iev_vector_s         vec;
	logic                         start, smask, busy, insrv;
	iev_pkg::iev_level_t          slevel, clevel;
	int                           errors, n_checks, n;
	// Kinds: 0 trap, 1 illegal, 2 debug, 3 nonmaskable, 4 peripheral, 5 dma0, 6 dma1
	iev_row_s rows [16] = '{
		'{3'h0, 5'h00, 16'h0040, 1'b0}, '{3'h0, 5'h0F, 16'h004F, 1'b0},
		'{3'h0, 5'h10, 16'h0050, 1'b0}, '{3'h0, 5'h1F, 16'h005F, 1'b0},
		'{3'h1, 5'h00, 16'h0060, 1'b0}, '{3'h2, 5'h00, 16'h0060, 1'b0},
		'{3'h3, 5'h00, 16'h0010, 1'b0}, '{3'h4, 5'h00, 16'h0080, 1'b1},
		'{3'h4, 5'h04, 16'h00C0, 1'b1}, '{3'h4, 5'h05, 16'h00F0, 1'b1},
		'{3'h4, 5'h0E, 16'h0180, 1'b1}, '{3'h4, 5'h0F, 16'h01D0, 1'b1},
		'{3'h4, 5'h14, 16'h0220, 1'b1}, '{3'h4, 5'h1A, 16'h0280, 1'b1},
		'{3'h5, 5'h00, 16'h0290, 1'b1}, '{3'h6, 5'h00, 16'h02A0, 1'b1}};

	iev_vectoring dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .nonmaskable_request_in(nmi),
		.trap_in(trap), .illegal_opcode_trap_in(ill), .debug_trap_in(dbg),
		.periph_req_in(preq), .periph_ctl_in(pctl), .dma_ch0_done_irq_in(dma0),
		.dma_ch1_done_irq_in(dma1), .dma_ch0_irq_ctl_in(d0ctl), .dma_ch1_irq_ctl_in(d1ctl),
		.int_enable_in(ien), .in_service_in(insrv), .cur_level_in(clevel), .vector_out(vec),
		.start_out(start), .start_maskable_out(smask), .start_level_out(slevel),
		.busy_out(busy));
	iev_core_model core (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .on_in(core_on), .start_in(start),
		.maskable_in(smask), .level_in(slevel), .in_service_out(insrv),
		.cur_level_out(clevel));

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic drive(input logic [2:0] k, input logic [4:0] a, input logic v);
		case (k)
			3'h0: trap <= '{v, a};
			3'h1: ill <= v;
			3'h2: dbg <= v;
			3'h3: nmi <= v;
			3'h4: preq[a] <= v;
			3'h5: dma0 <= v;
			default: dma1 <= v;
		endcase
	endtask

	// Counts edges until start_out is seen just after one
	task automatic wait_start(inout int c);
		do begin
			@(posedge clk_in);
			c++;
			#1;
		end while (start !== 1'b1 && c < 80);
		if (c >= 80) begin
			errors++;
			$display("mismatch start_out expected 1 seen timeout");
			end_sim();
		end
	endtask

	task automatic fire(input logic [2:0] k, input logic [4:0] a);
		@(posedge clk_in);
		drive(k, a, 1'b1);
		@(posedge clk_in);
		drive(k, a, 1'b0);
		n = 1;
		wait_start(n);
	endtask

	task automatic next_code(input logic [15:0] c);
		n = 0;
		wait_start(n);
		chk("code", 48'(c), 48'(vec.code));
	endtask

	initial begin
		{rst_b_in, nmi, ill, dbg, dma0, dma1, core_on} = '0;
		ien = 1'b1;
		ce = 1'b1;
		trap = '0;
		preq = '0;
		pctl = '0;
		d0ctl = '0;
		d1ctl = '0;
		errors = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_in);
		#1;
		chk("reset outputs", 48'h0, {46'h0, start, busy});
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		n = 0;
		wait_start(n);
		chk("reset latency", 48'h4, 48'(n));
		chk("reset vector", 48'h0, vec);
		$display("test reset done");
		foreach (rows[i]) begin
			fire(rows[i].kind, rows[i].arg);
			chk("latency", 48'h5, 48'(n));
			chk("vector", {rows[i].code, 16'h0, rows[i].code[15:4], 4'h0}, vec);
			chk("maskable", 48'(rows[i].mk), 48'(smask));
		end
		$display("test table done");
		@(posedge clk_in);
		{preq[20], preq[3], dma0} <= 3'b111;
		@(posedge clk_in);
		{preq[20], preq[3], dma0} <= 3'b000;
		next_code(16'h00B0);
		next_code(16'h0220);
		next_code(16'h0290);
		$display("test priority done");
		@(posedge clk_in);
		{ien, nmi, preq[1]} <= 3'b011;
		@(posedge clk_in);
		{nmi, preq[1]} <= 2'b00;
		next_code(16'h0010);
		repeat (20) begin
			@(posedge clk_in);
			#1;
			chk("held start", 48'h0, 48'(start));
		end
		@(posedge clk_in);
		ien <= 1'b1;
		next_code(16'h0090);
		$display("test nonmaskable done");
		@(posedge clk_in);
		core_on <= 1'b1;
		pctl[0].level <= 3'h5;
		pctl[1].level <= 3'h5;
		pctl[2].level <= 3'h2;
		fire(3'h4, 5'h01);
		chk("level", 48'h5, 48'(slevel));
		fire(3'h4, 5'h02);
		chk("nested", {16'h00A0, 32'h1}, {vec.code, 31'h0, insrv});
		chk("nested level", 48'h2, 48'(slevel));
		fire(3'h4, 5'h00);
		chk("after service", {16'h0080, 32'h0}, {vec.code, 31'h0, insrv});
		$display("test nesting done");
		@(posedge clk_in);
		{core_on, dma1} <= 2'b01;
		@(posedge clk_in);
		dma1 <= 1'b0;
		@(posedge clk_in);
		ce <= 1'b0;
		repeat (10) begin
			@(posedge clk_in);
			#1;
			chk("frozen start busy", 48'h1, {46'h0, start, busy});
		end
		@(posedge clk_in);
		ce <= 1'b1;
		n = 0;
		wait_start(n);
		chk("frozen latency", 48'h3, 48'(n));
		chk("frozen vector", {16'h02A0, 32'h0000_02A0}, vec);
		$display("test clock enable done");
		@(posedge clk_in);
		{nmi, ill, dma0} <= 3'b111;
		trap <= '{1'b1, 5'h13};
		@(posedge clk_in);
		{nmi, ill, dma0} <= 3'b000;
		trap <= '0;
		next_code(16'h0010);
		next_code(16'h0060);
		next_code(16'h0290);
		$display("test source order done");
		@(posedge clk_in);
		dma1 <= 1'b1;
		@(posedge clk_in);
		{rst_b_in, dma1} <= 2'b00;
		repeat (2) @(posedge clk_in);
		#1;
		chk("reset again outputs", 48'h0, {vec.code, 30'h0, start, busy});
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		n = 0;
		wait_start(n);
		chk("reset again latency", 48'h4, 48'(n));
		chk("reset again vector", 48'h0, vec);
		repeat (8) begin
			@(posedge clk_in);
			#1;
			chk("cleared request", 48'h0, 48'(start));
		end
		$display("test mid-run reset done");
		end_sim();
	end
endmodule // tb_iev_vectoring
`default_nettype wire
